/* design/ieb_pkg.sv */
package ieb_pkg;

  // Register word width and bus address width
  localparam int REG_W  = 16;
  localparam int ADDR_W = 6;

  // Byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFS_EN_LOW    = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_EN_HIGH   = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAG_LOW  = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAG_HIGH = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_PEND_LOW  = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_PEND_HIGH = 6'h14;

  // Values after reset and implemented-bit masks
  localparam logic [REG_W-1:0] EN_LOW_RESET  = 16'h0000;
  localparam logic [REG_W-1:0] EN_HIGH_RESET = 16'h0000;
  localparam logic [REG_W-1:0] EN_LOW_IMPL   = 16'h7fff;
  localparam logic [REG_W-1:0] EN_HIGH_IMPL  = 16'hffdf;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Register selected by an address
  typedef enum logic [2:0] {
    SEL_EN_LOW, SEL_EN_HIGH, SEL_FLAG_LOW, SEL_FLAG_HIGH,
    SEL_PEND_LOW, SEL_PEND_HIGH, SEL_NONE
  } ieb_sel_t;

  // Sources of the first word, bit 15 down to bit 0
  typedef struct packed {
    logic rsvd_15;
    logic xfer_ch1_done;
    logic conv_done;
    logic serial_a_tx;
    logic serial_a_rx;
    logic spi_a_event;
    logic spi_a_error;
    logic tmr_c;
    logic tmr_b;
    logic cmp_out_b;
    logic capture_b;
    logic xfer_ch0_done;
    logic tmr_a;
    logic cmp_out_a;
    logic capture_a;
    logic ext_pin_a;
  } ieb_low_t;

  // Sources of the second word, bit 15 down to bit 0
  typedef struct packed {
    logic serial_b_tx;
    logic serial_b_rx;
    logic ext_pin_c;
    logic tmr_e;
    logic tmr_d;
    logic cmp_out_d;
    logic cmp_out_c;
    logic xfer_ch2_done;
    logic capture_h;
    logic capture_g;
    logic rsvd_5;
    logic ext_pin_b;
    logic pin_change;
    logic analog_cmp;
    logic twowire_master;
    logic twowire_slave;
  } ieb_high_t;

  // Exact word match; misaligned or unknown addresses select nothing
  function automatic ieb_sel_t ieb_decode(input logic [ADDR_W-1:0] addr);
    ieb_sel_t sel;
    case (addr)
      OFS_EN_LOW:    sel = SEL_EN_LOW;
      OFS_EN_HIGH:   sel = SEL_EN_HIGH;
      OFS_FLAG_LOW:  sel = SEL_FLAG_LOW;
      OFS_FLAG_HIGH: sel = SEL_FLAG_HIGH;
      OFS_PEND_LOW:  sel = SEL_PEND_LOW;
      OFS_PEND_HIGH: sel = SEL_PEND_HIGH;
      default:       sel = SEL_NONE;
    endcase
    return sel;
  endfunction : ieb_decode

endpackage : ieb_pkg

/* design/ieb_enable_reg.sv */
`timescale 1ns/1ps
module ieb_enable_reg
  import ieb_pkg::*;
#(
  parameter int               WIDTH = REG_W,
  parameter logic [WIDTH-1:0] IMPL  = '1,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [WIDTH/8-1:0] wr_strb,
  // Stored value
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] next_q;

  // Byte-lane merge; unimplemented bits forced to zero
  always_comb begin
    next_q = q;
    for (int i = 0; i < WIDTH; i++) begin
      if (wr_strb[i/8]) begin
        next_q[i] = wr_data[i] & IMPL[i];
      end
    end
  end

  // Reset wins over the clock enable
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RST & IMPL;
    end else if (ce && wr_en) begin
      q <= next_q;
    end
  end

endmodule : ieb_enable_reg

/* design/ieb_bus_wr.sv */
`timescale 1ns/1ps
module ieb_bus_wr
  import ieb_pkg::*;
(
  // Clock and control
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  // Write address channel
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  // Write data channel
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // Write response channel
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // Held write toward the register file
  output logic                   wr_go,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic [1:0]        wr_resp
);

  logic aw_held;
  logic w_held;

  // Each channel taken once, in either order
  assign awready = ce & ~aw_held;
  assign wready  = ce & ~w_held;
  // One write at a time: wait for the previous response to drain
  assign wr_go   = ce & aw_held & w_held & ~bvalid;

  // Address and data capture
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Response held until the master takes it
  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_resp;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

endmodule : ieb_bus_wr

/* design/ieb_top.sv */
`timescale 1ns/1ps
module ieb_top
  import ieb_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  // AXI4-Lite write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  // AXI4-Lite write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // AXI4-Lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // AXI4-Lite read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  // AXI4-Lite read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // Request flags from the sources
  input  wire ieb_low_t          flag_low,
  input  wire ieb_high_t         flag_high,
  // Gated requests to the processor
  output ieb_low_t               req_low,
  output ieb_high_t              req_high,
  output logic                   req_any
);

  // Write path wires
  logic              wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [1:0]        wr_resp;
  ieb_sel_t          wr_sel;
  logic              wr_en_low;
  logic              wr_en_high;

  // Read path wires
  ieb_sel_t          rd_sel;
  logic [REG_W-1:0]  rd_word;
  logic [1:0]        rd_resp;
  logic              rd_take;

  // Stored enables
  logic [REG_W-1:0]  en_low_q;
  logic [REG_W-1:0]  en_high_q;
  ieb_low_t          en_lo;
  ieb_high_t         en_hi;

  // Named enable bits, first word
  logic              xfer_ch1_done_en;
  logic              conv_done_en;
  logic              serial_a_tx_en;
  logic              serial_a_rx_en;
  logic              spi_a_event_en;
  logic              spi_a_error_en;
  logic              tmr_c_en;
  logic              tmr_b_en;
  logic              cmp_out_b_en;
  logic              capture_b_en;
  logic              xfer_ch0_done_en;
  logic              tmr_a_en;
  logic              cmp_out_a_en;
  logic              capture_a_en;
  logic              ext_pin_a_en;

  // Named enable bits, second word
  logic              serial_b_tx_en;
  logic              serial_b_rx_en;
  logic              ext_pin_c_en;
  logic              tmr_e_en;
  logic              tmr_d_en;
  logic              cmp_out_d_en;
  logic              cmp_out_c_en;
  logic              xfer_ch2_done_en;
  logic              capture_h_en;
  logic              capture_g_en;
  logic              ext_pin_b_en;
  logic              pin_change_en;
  logic              analog_cmp_en;
  logic              twowire_master_en;
  logic              twowire_slave_en;

  // Write channel capture and response
  ieb_bus_wr u_bus_wr (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_resp (wr_resp)
  );

  // Write decode; flag and pending views are read-only
  assign wr_sel     = ieb_decode(wr_addr);
  assign wr_en_low  = wr_go & (wr_sel == SEL_EN_LOW);
  assign wr_en_high = wr_go & (wr_sel == SEL_EN_HIGH);
  assign wr_resp    = (wr_sel == SEL_EN_LOW || wr_sel == SEL_EN_HIGH) ? RESP_OKAY :
                      (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_SLVERR;

  // First enable word, bit 15 held at zero
  ieb_enable_reg #(
    .WIDTH (REG_W),
    .IMPL  (EN_LOW_IMPL),
    .RST   (EN_LOW_RESET)
  ) u_en_low (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .wr_en   (wr_en_low),
    .wr_data (wr_data[REG_W-1:0]),
    .wr_strb (wr_strb[1:0]),
    .q       (en_low_q)
  );

  // Second enable word, bit 5 held at zero
  ieb_enable_reg #(
    .WIDTH (REG_W),
    .IMPL  (EN_HIGH_IMPL),
    .RST   (EN_HIGH_RESET)
  ) u_en_high (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .wr_en   (wr_en_high),
    .wr_data (wr_data[REG_W-1:0]),
    .wr_strb (wr_strb[1:0]),
    .q       (en_high_q)
  );

  // Struct views of the stored words
  assign en_lo = ieb_low_t'(en_low_q);
  assign en_hi = ieb_high_t'(en_high_q);

  // Field map of the first word
  assign xfer_ch1_done_en = en_lo.xfer_ch1_done;
  assign xfer_ch0_done_en = en_lo.xfer_ch0_done;
  assign conv_done_en     = en_lo.conv_done;
  assign serial_a_tx_en   = en_lo.serial_a_tx;
  assign serial_a_rx_en   = en_lo.serial_a_rx;
  assign spi_a_event_en   = en_lo.spi_a_event;
  assign spi_a_error_en   = en_lo.spi_a_error;
  assign tmr_a_en         = en_lo.tmr_a;
  assign tmr_b_en         = en_lo.tmr_b;
  assign tmr_c_en         = en_lo.tmr_c;
  assign cmp_out_a_en     = en_lo.cmp_out_a;
  assign cmp_out_b_en     = en_lo.cmp_out_b;
  assign capture_a_en     = en_lo.capture_a;
  assign capture_b_en     = en_lo.capture_b;
  assign ext_pin_a_en     = en_lo.ext_pin_a;

  // Field map of the second word
  assign xfer_ch2_done_en  = en_hi.xfer_ch2_done;
  assign serial_b_tx_en    = en_hi.serial_b_tx;
  assign serial_b_rx_en    = en_hi.serial_b_rx;
  assign tmr_d_en          = en_hi.tmr_d;
  assign tmr_e_en          = en_hi.tmr_e;
  assign cmp_out_c_en      = en_hi.cmp_out_c;
  assign cmp_out_d_en      = en_hi.cmp_out_d;
  assign capture_g_en      = en_hi.capture_g;
  assign capture_h_en      = en_hi.capture_h;
  assign ext_pin_b_en      = en_hi.ext_pin_b;
  assign ext_pin_c_en      = en_hi.ext_pin_c;
  assign pin_change_en     = en_hi.pin_change;
  assign analog_cmp_en     = en_hi.analog_cmp;
  assign twowire_master_en = en_hi.twowire_master;
  assign twowire_slave_en  = en_hi.twowire_slave;

  // Gating is pure AND: no delay, and flags are only read here
  assign req_low.rsvd_15       = 1'b0;
  assign req_low.xfer_ch1_done = flag_low.xfer_ch1_done & xfer_ch1_done_en;
  assign req_low.conv_done     = flag_low.conv_done & conv_done_en;
  assign req_low.serial_a_tx   = flag_low.serial_a_tx & serial_a_tx_en;
  assign req_low.serial_a_rx   = flag_low.serial_a_rx & serial_a_rx_en;
  assign req_low.spi_a_event   = flag_low.spi_a_event & spi_a_event_en;
  assign req_low.spi_a_error   = flag_low.spi_a_error & spi_a_error_en;
  assign req_low.tmr_c         = flag_low.tmr_c & tmr_c_en;
  assign req_low.tmr_b         = flag_low.tmr_b & tmr_b_en;
  assign req_low.cmp_out_b     = flag_low.cmp_out_b & cmp_out_b_en;
  assign req_low.capture_b     = flag_low.capture_b & capture_b_en;
  assign req_low.xfer_ch0_done = flag_low.xfer_ch0_done & xfer_ch0_done_en;
  assign req_low.tmr_a         = flag_low.tmr_a & tmr_a_en;
  assign req_low.cmp_out_a     = flag_low.cmp_out_a & cmp_out_a_en;
  assign req_low.capture_a     = flag_low.capture_a & capture_a_en;
  assign req_low.ext_pin_a     = flag_low.ext_pin_a & ext_pin_a_en;

  // Second word gating
  assign req_high.serial_b_tx    = flag_high.serial_b_tx & serial_b_tx_en;
  assign req_high.serial_b_rx    = flag_high.serial_b_rx & serial_b_rx_en;
  assign req_high.ext_pin_c      = flag_high.ext_pin_c & ext_pin_c_en;
  assign req_high.tmr_e          = flag_high.tmr_e & tmr_e_en;
  assign req_high.tmr_d          = flag_high.tmr_d & tmr_d_en;
  assign req_high.cmp_out_d      = flag_high.cmp_out_d & cmp_out_d_en;
  assign req_high.cmp_out_c      = flag_high.cmp_out_c & cmp_out_c_en;
  assign req_high.xfer_ch2_done  = flag_high.xfer_ch2_done & xfer_ch2_done_en;
  assign req_high.capture_h      = flag_high.capture_h & capture_h_en;
  assign req_high.capture_g      = flag_high.capture_g & capture_g_en;
  assign req_high.rsvd_5         = 1'b0;
  assign req_high.ext_pin_b      = flag_high.ext_pin_b & ext_pin_b_en;
  assign req_high.pin_change     = flag_high.pin_change & pin_change_en;
  assign req_high.analog_cmp     = flag_high.analog_cmp & analog_cmp_en;
  assign req_high.twowire_master = flag_high.twowire_master & twowire_master_en;
  assign req_high.twowire_slave  = flag_high.twowire_slave & twowire_slave_en;

  // Summary line for the processor's wake logic
  assign req_any = (|req_low) | (|req_high);

  // Read decode; flag view shows inputs untouched, reserved bits masked
  assign rd_sel  = ieb_decode(araddr);
  assign rd_take = arvalid & arready;
  assign rd_word = (rd_sel == SEL_EN_LOW)    ? en_low_q :
                   (rd_sel == SEL_EN_HIGH)   ? en_high_q :
                   (rd_sel == SEL_FLAG_LOW)  ? (REG_W'(flag_low) & EN_LOW_IMPL) :
                   (rd_sel == SEL_FLAG_HIGH) ? (REG_W'(flag_high) & EN_HIGH_IMPL) :
                   (rd_sel == SEL_PEND_LOW)  ? REG_W'(req_low) :
                   (rd_sel == SEL_PEND_HIGH) ? REG_W'(req_high) : '0;
  assign rd_resp = (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;

  // One read at a time: address refused while data waits
  assign arready = ce & ~rvalid;

  // Read data registered at the accept edge
  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata  <= {16'h0000, rd_word};  // Upper half reads zero
        rresp  <= rd_resp;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule : ieb_top

/* testbench/ieb_top_chk.sv */
`timescale 1ns/1ps
module ieb_top_chk
  import ieb_pkg::*;
(
  // Clock and control
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  // Bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  // Flags and requests
  input wire ieb_low_t    flag_low,
  input wire ieb_high_t   flag_high,
  input wire ieb_low_t    req_low,
  input wire ieb_high_t   req_high,
  input wire logic        req_any
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Acceptance steps of a write and of a read
  sequence wr_both_taken;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence

  // A request may only pass where its flag is up
  a_req_needs_flag: assert property (((req_low & ~flag_low) == '0) && ((req_high & ~flag_high) == '0))
    else $error("request seen without its flag");
  a_any_is_or: assert property (req_any == ((|req_low) || (|req_high)))
    else $error("summary request differs from the request bits");
  a_rsvd_quiet: assert property (!req_low.rsvd_15 && !req_high.rsvd_5)
    else $error("reserved request position driven");
  // Enables start cleared, so nothing passes right after reset
  a_reset_blocks: assert property ($fell(srst) |-> (req_low == '0) && (req_high == '0))
    else $error("request passed straight after reset");
  // Write answer two edges after both halves are taken
  a_write_answer: assert property (wr_both_taken ##1 ce |=> bvalid)
    else $error("write response late");
  a_read_answer: assert property (rd_taken |=> rvalid)
    else $error("read response late");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // Frozen block takes nothing
  a_ce_freeze: assert property (!ce |-> !awready && !wready && !arready)
    else $error("handshake ready while frozen");
endmodule : ieb_top_chk

bind ieb_top ieb_top_chk u_chk (
  .clk(clk), .srst(srst), .ce(ce), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rdata(rdata), .flag_low(flag_low), .flag_high(flag_high), .req_low(req_low),
  .req_high(req_high), .req_any(req_any)
);

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import ieb_pkg::*;
();
  logic              clk, srst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, req_any;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0]        awprot, arprot;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  ieb_low_t          flag_low, req_low;
  ieb_high_t         flag_high, req_high;
  int                errors, n_tests;

  ieb_top DUT (
    .clk(clk), .srst(srst), .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .flag_low(flag_low), .flag_high(flag_high), .req_low(req_low),
    .req_high(req_high), .req_any(req_any)
  );

  // Clock at 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Address and data offered together, each dropped once taken
  // No cycle limit of its own: only the watchdog ends a hung wait
  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    check({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask : wr_chk

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask : rd_chk

  // Flags change on an edge, requests looked at mid-cycle
  task automatic set_flags(input logic [15:0] l, input logic [15:0] h);
    @(posedge clk);
    flag_low <= ieb_low_t'(l);
    flag_high <= ieb_high_t'(h);
    @(negedge clk);
  endtask : set_flags

  // One enable pattern against the named sources, all flags up
  task automatic grp(input logic [15:0] ml, input ieb_low_t el, input logic [15:0] mh, input ieb_high_t eh);
    wr_chk(OFS_EN_LOW, {16'h0, ml}, 4'h3, RESP_OKAY);
    wr_chk(OFS_EN_HIGH, {16'h0, mh}, 4'h3, RESP_OKAY);
    @(negedge clk);
    check({16'h0, req_low}, {16'h0, el});
    check({16'h0, req_high}, {16'h0, eh});
  endtask : grp

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    n_tests = 0;
    srst = 1'b1;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    awprot = 3'h0;
    arprot = 3'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    flag_low = '0;
    flag_high = '0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd_chk(OFS_EN_LOW, 32'h0, RESP_OKAY);
    rd_chk(OFS_EN_HIGH, 32'h0, RESP_OKAY);
    // Reserved positions drop written ones
    wr_chk(OFS_EN_LOW, 32'hffffffff, 4'hf, RESP_OKAY);
    wr_chk(OFS_EN_HIGH, 32'hffffffff, 4'hf, RESP_OKAY);
    rd_chk(OFS_EN_LOW, 32'h00007fff, RESP_OKAY);
    rd_chk(OFS_EN_HIGH, 32'h0000ffdf, RESP_OKAY);
    set_flags(16'hffff, 16'hffff);
    check({16'h0, req_low}, 32'h7fff);
    check({16'h0, req_high}, 32'hffdf);
    // Lower byte lane alone
    wr_chk(OFS_EN_LOW, 32'h0, 4'h1, RESP_OKAY);
    rd_chk(OFS_EN_LOW, 32'h00007f00, RESP_OKAY);
    // Walking enable: only the chosen source passes
    for (int i = 0; i < 16; i++) begin
      grp(16'h1 << i, ieb_low_t'(16'h1 << i) & ieb_low_t'(EN_LOW_IMPL),
          16'h1 << i, ieb_high_t'(16'h1 << i) & ieb_high_t'(EN_HIGH_IMPL));
    end
    grp(16'h6010, '{xfer_ch1_done: 1'b1, xfer_ch0_done: 1'b1, conv_done: 1'b1, default: 1'b0},
        16'h0100, '{xfer_ch2_done: 1'b1, default: 1'b0});
    grp(16'h1e00, '{serial_a_tx: 1'b1, serial_a_rx: 1'b1, spi_a_event: 1'b1, spi_a_error: 1'b1, default: 1'b0},
        16'hc000, '{serial_b_tx: 1'b1, serial_b_rx: 1'b1, default: 1'b0});
    grp(16'h0188, '{tmr_a: 1'b1, tmr_b: 1'b1, tmr_c: 1'b1, default: 1'b0},
        16'h1800, '{tmr_d: 1'b1, tmr_e: 1'b1, default: 1'b0});
    grp(16'h0066, '{cmp_out_a: 1'b1, cmp_out_b: 1'b1, capture_a: 1'b1, capture_b: 1'b1, default: 1'b0},
        16'h06c0, '{cmp_out_c: 1'b1, cmp_out_d: 1'b1, capture_g: 1'b1, capture_h: 1'b1, default: 1'b0});
    grp(16'h0001, '{ext_pin_a: 1'b1, default: 1'b0},
        16'h201f, '{ext_pin_b: 1'b1, ext_pin_c: 1'b1, pin_change: 1'b1, analog_cmp: 1'b1,
                    twowire_master: 1'b1, twowire_slave: 1'b1, default: 1'b0});
    // Gating against a mixed flag pattern; enables never touch the flags
    set_flags(16'hbcc3, 16'h0000);
    check({31'h0, req_any}, 32'h1);
    wr_chk(OFS_EN_LOW, 32'h0f0f, 4'h3, RESP_OKAY);
    @(negedge clk);
    check({16'h0, req_low}, 32'h0c03);
    rd_chk(OFS_PEND_LOW, 32'h00000c03, RESP_OKAY);
    rd_chk(OFS_FLAG_LOW, 32'h00003cc3, RESP_OKAY);
    wr_chk(OFS_EN_LOW, 32'h0, 4'h3, RESP_OKAY);
    wr_chk(OFS_FLAG_LOW, 32'h0, 4'h3, RESP_SLVERR);
    rd_chk(OFS_FLAG_LOW, 32'h00003cc3, RESP_OKAY);
    check({31'h0, req_any}, 32'h0);
    set_flags(16'h0000, 16'h0000);
    // Unmapped and misaligned places
    wr_chk(6'h20, 32'hffff, 4'h3, RESP_DECERR);
    wr_chk(6'h02, 32'hffff, 4'h3, RESP_DECERR);
    rd_chk(6'h20, 32'h0, RESP_DECERR);
    rd_chk(OFS_EN_LOW, 32'h0, RESP_OKAY);
    // Frozen clock enable keeps state
    wr_chk(OFS_EN_HIGH, 32'h0001, 4'h3, RESP_OKAY);
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    check({29'h0, awready, wready, arready}, 32'h0);
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    rd_chk(OFS_EN_HIGH, 32'h00000001, RESP_OKAY);
    // Reset in mid-run clears the enables again
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    set_flags(16'hffff, 16'hffff);
    check({31'h0, req_any}, 32'h0);
    rd_chk(OFS_EN_HIGH, 32'h0, RESP_OKAY);
    report_and_stop();
  end
endmodule : tb_top
